// ==== hw/ppdc_top.sv ====
// Port pull-up and direction control, all ports in one module.
// Assumes an APB master on CLK and a synchronous active-high reset.
//
// Function
// - Pull-up on when pin is input and its pull-up bit is one.
// - Pull-up settings and state kept through deep software standby.
// - Pull-up off when pin is general or peripheral output.
// - Pull-up off for external bus pins, except the bus wait input.
// - Direction bit zero selects input, one selects output.
// - Pins stay inputs from reset release until software sets output.
`timescale 1ns/1ns
module ppdc_top
    import ppdc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [PPDC_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic DEEP_STANDBY,
    input wire ppdc_use_t [PPDC_PORTS-1:0] PIN_USE,
    output ppdc_pad_t [PPDC_PORTS-1:0] PAD_CTRL
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [PPDC_PINS-1:0] dir_ctrl [PPDC_PORTS];
    logic [PPDC_PINS-1:0] pullup_ctrl [PPDC_PORTS];
    logic [PPDC_PINS-1:0] next_dir_ctrl [PPDC_PORTS];
    logic [PPDC_PINS-1:0] next_pullup_ctrl [PPDC_PORTS];
    logic [PPDC_PINS-1:0] pin_status [PPDC_PORTS];
    logic [PPDC_PINS-1:0] pullup_gate [PPDC_PORTS];
    logic [PPDC_PINS-1:0] drive_gate [PPDC_PORTS];
    ppdc_pad_t [PPDC_PORTS-1:0] pad;
    ppdc_pad_t [PPDC_PORTS-1:0] next_pad;

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    ppdc_state_t state;
    ppdc_state_t next_state;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [PPDC_PINS-1:0] read_word;
    logic read_err;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [PPDC_AW-1:0] reg_ofs;
    logic [PPDC_AW-PPDC_PORT_SEL_LSB-1:0] port_sel;
    logic [$clog2(PPDC_PORTS)-1:0] port_idx;
    logic port_ok;
    logic setup;
    logic wr_en;

    assign reg_ofs = PADDR & (PPDC_PORT_STRIDE - 8'h01);
    assign port_sel = PADDR[PPDC_AW-1:PPDC_PORT_SEL_LSB];
    assign port_idx = port_sel[$clog2(PPDC_PORTS)-1:0];
    assign port_ok = (int'(port_sel) < PPDC_PORTS) && (PADDR[1:0] == 2'h0);
    assign setup = PSEL && !PENABLE;

    assign wr_en = (state == PPDC_ACCESS) && PWRITE && !PSLVERR
        && PSTRB[0] && !DEEP_STANDBY;

    // ------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < PPDC_PORTS; p++) begin
            next_dir_ctrl[p] = dir_ctrl[p];
        end
        if (wr_en && (reg_ofs == PPDC_OFS_DIR)) begin
            next_dir_ctrl[port_idx] = PWDATA[PPDC_PINS-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int p = 0; p < PPDC_PORTS; p++) begin
                dir_ctrl[p] <= PPDC_RST_DIR;
            end
        end else begin
            for (int p = 0; p < PPDC_PORTS; p++) begin
                dir_ctrl[p] <= next_dir_ctrl[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Pull-up register
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < PPDC_PORTS; p++) begin
            next_pullup_ctrl[p] = pullup_ctrl[p];
        end
        if (wr_en && (reg_ofs == PPDC_OFS_PULLUP)) begin
            next_pullup_ctrl[port_idx] = PWDATA[PPDC_PINS-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int p = 0; p < PPDC_PORTS; p++) begin
                pullup_ctrl[p] <= PPDC_RST_PULLUP;
            end
        end else begin
            for (int p = 0; p < PPDC_PORTS; p++) begin
                pullup_ctrl[p] <= next_pullup_ctrl[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Pad control per pin
    // ------------------------------------------------------------
    genvar gp, gb;
    generate
        for (gp = 0; gp < PPDC_PORTS; gp++) begin : g_port
            for (gb = 0; gb < PPDC_PINS; gb++) begin : g_pin
                logic is_out;
                logic bus_force;
                assign is_out = (dir_ctrl[gp][gb] == PPDC_DIR_OUT)
                    || PIN_USE[gp].periph_out[gb];
                assign bus_force = PIN_USE[gp].ext_bus[gb]
                    && !PIN_USE[gp].bus_wait[gb];
                assign pullup_gate[gp][gb] = pullup_ctrl[gp][gb]
                    && !is_out && !bus_force;
                assign drive_gate[gp][gb] = dir_ctrl[gp][gb] == PPDC_DIR_OUT;
                assign pin_status[gp][gb] = pad[gp].pullup_on[gb];
            end
        end
    endgenerate

    always_comb begin
        for (int p = 0; p < PPDC_PORTS; p++) begin
            next_pad[p].pullup_on = pullup_gate[p];
            next_pad[p].drive_en = drive_gate[p];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pad <= '0;
        end else begin
            pad <= next_pad;
        end
    end

    // ------------------------------------------------------------
    // Read data and error select
    // ------------------------------------------------------------
    always_comb begin
        read_word = 8'h00;
        read_err = 1'b0;
        if (!port_ok) begin
            read_err = 1'b1;
        end else if (reg_ofs == PPDC_OFS_DIR) begin
            read_word = dir_ctrl[port_idx];
        end else if (reg_ofs == PPDC_OFS_PULLUP) begin
            read_word = pullup_ctrl[port_idx];
        end else if (reg_ofs == PPDC_OFS_STATUS) begin
            read_word = pin_status[port_idx];
            read_err = PWRITE;
        end else begin
            read_err = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_prdata = PRDATA;
        next_pslverr = 1'b0;
        case (state)
            PPDC_IDLE: begin
                if (setup) begin
                    next_state = PPDC_ACCESS;
                    next_prdata = {{(32-PPDC_PINS){1'b0}}, read_word};
                    next_pslverr = read_err;
                end
            end
            PPDC_ACCESS: begin
                next_state = PPDC_IDLE;
                next_pslverr = PSLVERR;
            end
            default: begin
                next_state = PPDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= PPDC_IDLE;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            state <= next_state;
            PRDATA <= next_prdata;
            PSLVERR <= next_pslverr;
        end
    end

    assign PREADY = (state == PPDC_ACCESS);
    assign PAD_CTRL = pad;

endmodule

// ==== include/ppdc_pkg.sv ====
// Package for the port pull-up and direction control block.
// Assumes an APB register bus with 32-bit data and one word per register.
package ppdc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PPDC_PORTS = 4;
    localparam int PPDC_PINS = 8;
    localparam int PPDC_AW = 8;

    // ------------------------------------------------------------
    // Register map: per port a block of four words
    // ------------------------------------------------------------
    localparam logic [7:0] PPDC_OFS_DIR = 8'h00;
    localparam logic [7:0] PPDC_OFS_PULLUP = 8'h04;
    localparam logic [7:0] PPDC_OFS_STATUS = 8'h08;
    localparam logic [7:0] PPDC_PORT_STRIDE = 8'h10;
    localparam int PPDC_PORT_SEL_LSB = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PPDC_RST_DIR = 8'h00;
    localparam logic [7:0] PPDC_RST_PULLUP = 8'h00;

    // ------------------------------------------------------------
    // Direction encoding
    // ------------------------------------------------------------
    localparam logic PPDC_DIR_IN = 1'b0;
    localparam logic PPDC_DIR_OUT = 1'b1;

    // ------------------------------------------------------------
    // Pin usage from the rest of the chip, one struct per port
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PPDC_PINS-1:0] periph_out;
        logic [PPDC_PINS-1:0] ext_bus;
        logic [PPDC_PINS-1:0] bus_wait;
    } ppdc_use_t;

    typedef struct packed {
        logic [PPDC_PINS-1:0] pullup_on;
        logic [PPDC_PINS-1:0] drive_en;
    } ppdc_pad_t;

    typedef enum logic [1:0] {
        PPDC_IDLE,
        PPDC_ACCESS
    } ppdc_state_t;

endpackage

// ==== sim/ppdc_chk.sv ====
// Checker for the port pull-up and direction block.
// Assumes it is bound to ppdc_top and sees only its ports.
`timescale 1ns/1ns
module ppdc_chk
    import ppdc_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [PPDC_AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic DEEP_STANDBY,
    input wire ppdc_use_t [PPDC_PORTS-1:0] PIN_USE,
    input wire ppdc_pad_t [PPDC_PORTS-1:0] PAD_CTRL
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic wr_acc;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    for (genvar p = 0; p < PPDC_PORTS; p++) begin : g_port
        pu_out_off_a: assert property (
            (PAD_CTRL[p].pullup_on & PAD_CTRL[p].drive_en) == 8'h00)
            else $error("pull-up on an output pin");
        pu_periph_a: assert property (
            (PAD_CTRL[p].pullup_on & $past(PIN_USE[p].periph_out)) == 8'h00)
            else $error("pull-up on a peripheral output pin");
        pu_ext_bus_a: assert property ((PAD_CTRL[p].pullup_on
            & $past(PIN_USE[p].ext_bus) & ~$past(PIN_USE[p].bus_wait)) == 8'h00)
            else $error("pull-up on an external bus pin");
        dir_hold_a: assert property (
            !$stable(PAD_CTRL[p].drive_en) |-> $past(wr_acc, 2))
            else $error("direction changed without a write");
    end
    dir_write_a: assert property (wr_acc && PREADY && !PSLVERR
        && !DEEP_STANDBY && PSTRB[0] && PADDR == PPDC_OFS_DIR
        |=> ##1 PAD_CTRL[0].drive_en == $past(PWDATA[7:0], 2))
        else $error("drive enable differs from written direction");
    standby_keep_a: assert property (
        wr_acc && PREADY && DEEP_STANDBY |=> ##1 $stable(PAD_CTRL[0].drive_en))
        else $error("write in deep standby changed the pins");
    ready_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in the access cycle");
    ready_low_a: assert property (!PENABLE |-> !PREADY)
        else $error("ready outside the access phase");
    bad_addr_a: assert property (
        PSEL && !PENABLE && PADDR[3:0] == 4'hC |=> PSLVERR && PREADY)
        else $error("unmapped offset not refused");
endmodule
bind ppdc_top ppdc_chk chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DEEP_STANDBY(DEEP_STANDBY), .PIN_USE(PIN_USE), .PAD_CTRL(PAD_CTRL));

// ==== sim/ppdc_far.sv ====
// Far-side model: pin usage coming from the rest of the chip.
// Assumes the bench picks the usage mode at a clock edge.
`timescale 1ns/1ns
module ppdc_far
    import ppdc_pkg::*;
(
    input wire logic [1:0] mode,
    output ppdc_use_t [PPDC_PORTS-1:0] pin_use
);
    // Mode 1 peripheral out, 2 bus pins, 3 bus pins with wait on pin 4
    // Mode 0 leaves pins unused
    always_comb begin
        for (int i = 0; i < PPDC_PORTS; i++) begin
            pin_use[i].periph_out = {PPDC_PINS{mode == 2'h1}};
            pin_use[i].ext_bus = {PPDC_PINS{mode[1]}};
            pin_use[i].bus_wait = (mode == 2'h3) ? 8'h10 : 8'h00;
        end
    end
endmodule

// ==== sim/ppdc_top_test.sv ====
// Testbench for the port pull-up and direction block.
// Assumes the checker is bound in and the far-side model drives pin usage.
`timescale 1ns/1ns
module ppdc_top_test
    import ppdc_pkg::*;
;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, standby, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] mode;
    logic [3:0] pstrb;
    ppdc_use_t [PPDC_PORTS-1:0] pin_use;
    ppdc_pad_t [PPDC_PORTS-1:0] pad;
    int miscompares, check_count;
    logic [7:0] exp_pu [4] = '{8'hF0, 8'h00, 8'h00, 8'h10};
    ppdc_top dut_u (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .DEEP_STANDBY(standby), .PIN_USE(pin_use), .PAD_CTRL(pad));
    ppdc_far far_u (.mode(mode), .pin_use(pin_use));
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'h1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 8'h00);
        chk(rd, e);
        chk({31'h0, err}, 32'h0);
    endtask
    task automatic errchk(input logic w, input logic [7:0] a);
        apb(w, a, 8'h00);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic padchk(input int p, input logic [15:0] e);
        repeat (2) @(negedge clk);
        chk({16'h0, pad[p]}, {16'h0, e});
    endtask
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
        standby = 1'h0;
        mode = 2'h0;
        pstrb = 4'hF;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        rdchk(PPDC_OFS_DIR, {24'h0, PPDC_RST_DIR});
        rdchk(PPDC_OFS_PULLUP, {24'h0, PPDC_RST_PULLUP});
        padchk(0, 16'h0000);
        apb(1'h1, PPDC_OFS_PULLUP, 8'hFF);
        apb(1'h1, PPDC_OFS_DIR, 8'h0F);
        padchk(0, 16'hF00F);
        rdchk(PPDC_OFS_DIR, 32'h0F);
        rdchk(PPDC_OFS_STATUS, 32'hF0);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            mode <= m[1:0];
            padchk(0, {exp_pu[m], 8'h0F});
        end
        @(posedge clk);
        mode <= 2'h0;
        standby <= 1'h1;
        apb(1'h1, PPDC_OFS_DIR, 8'hF0);
        padchk(0, 16'hF00F);
        rdchk(PPDC_OFS_DIR, 32'h0F);
        apb(1'h1, PPDC_OFS_PULLUP, 8'h00);
        rdchk(PPDC_OFS_PULLUP, 32'hFF);
        standby <= 1'h0;
        errchk(1'h0, 8'h0C);
        errchk(1'h0, 8'h40);
        errchk(1'h1, PPDC_OFS_STATUS);
        errchk(1'h0, 8'h01);
        apb(1'h1, 8'h30, 8'hA5);
        rdchk(8'h30, 32'hA5);
        pstrb <= 4'hE;
        apb(1'h1, 8'h30, 8'h00);
        pstrb <= 4'hF;
        rdchk(8'h30, 32'hA5);
        apb(1'h1, 8'h34, 8'hFF);
        padchk(3, 16'h5AA5);
        print_verdict();
    end
endmodule
